//--- rtl/typec_src_defines.svh
// Register offsets, field positions, reset values and status codes of the source port block.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef TYPEC_SRC_DEFINES_SVH
`define TYPEC_SRC_DEFINES_SVH

`define I2C_DEV_ADDR 7'h28

`define OFS_CONN 8'h0e
`define OFS_OP 8'h11
`define OFS_CC_CTRL 8'h18
`define OFS_ILIM 8'h1e
`define OFS_ROLE 8'h1f
`define OFS_VCONN_MON 8'h20
`define OFS_TARGET 8'h21
`define OFS_SHIFT 8'h22
`define OFS_ACC 8'h24
`define OFS_DIS_TIME 8'h25
`define OFS_DIS_CTRL 8'h26
`define OFS_SUPPLY 8'h2e

`define RST_STARTUP 8'h00
`define RST_CC_CTRL 8'h01
`define RST_ILIM 8'h00
`define RST_ROLE 8'h00
`define RST_VCONN_MON 8'h01
`define RST_TARGET 8'h32
`define RST_SHIFT 8'haa
`define RST_ACC 8'h00
`define RST_DIS_TIME 8'haa
`define RST_DIS_CTRL 8'h01
`define RST_SUPPLY 8'h10

`define MASK_STARTUP 8'h01
`define MASK_CC_CTRL 8'hd1
`define MASK_ILIM 8'h0f
`define MASK_ROLE 8'h0f
`define MASK_VCONN_MON 8'h03
`define MASK_TARGET 8'hff
`define MASK_SHIFT 8'hff
`define MASK_ACC 8'h01
`define MASK_DIS_TIME 8'hff
`define MASK_DIS_CTRL 8'h01
`define MASK_SUPPLY 8'h1f

`define ROLE_SOURCE_ACC 4'h0

`define CONN_NONE 8'h00
`define CONN_SINK 8'h2d
`define CONN_SINK_CABLE 8'h2f
`define CONN_DEBUG 8'h6d
`define CONN_AUDIO 8'h81

`define OP_UNATTACHED 8'h00
`define OP_ATTACHED 8'h01
`define OP_DEBUG 8'h02
`define OP_AUDIO 8'h03

`endif

//--- rtl/typec_src_pkg.sv
// Types shared by the source port block: terminations, state codes and the state record.
// Assumes the defines header sits beside it on the include path.
package typec_src_pkg;
  typedef enum logic [1:0] {TERM_OPEN = 2'h0, TERM_RA = 2'h1, TERM_RD = 2'h2, TERM_RP = 2'h3} term_e;

  typedef enum logic [3:0] {
    ST_UNATT = 4'h1,
    ST_ATT = 4'h2,
    ST_DBG = 4'h4,
    ST_AUDIO = 4'h8
  } attach_e;

  typedef enum logic [8:0] {
    I_IDLE = 9'h001,
    I_ADDR = 9'h002,
    I_ACK_ADDR = 9'h004,
    I_PTR = 9'h008,
    I_ACK_PTR = 9'h010,
    I_WDATA = 9'h020,
    I_ACK_W = 9'h040,
    I_RDATA = 9'h080,
    I_ACK_R = 9'h100
  } i2c_e;

  localparam int NRW = 11;

  typedef struct packed {
    logic startup_standby;
    logic [1:0] advertised_current_field;
    logic cable_supply_discharge_on;
    logic cable_supply_allow;
    logic [3:0] cable_supply_current_limit;
    logic [3:0] power_role;
    logic cable_supply_uv_watch_on;
    logic cable_supply_uv_level;
    logic [7:0] bus_voltage_target;
    logic [3:0] bus_window_high_shift;
    logic [3:0] bus_window_low_shift;
    logic powered_accessory_detect_on;
    logic [3:0] discharge_to_zero_time;
    logic [3:0] discharge_transition_time;
    logic bus_discharge_on;
    logic supply_ov_detect_off;
    logic bus_range_detect_off;
    logic [1:0] bus_zero_volt_level;
    logic supply_uv_detect_off;
  } config_s;

  typedef struct packed {
    i2c_e bus;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic sda_low;
    logic scl_q;
    logic sda_q;
    attach_e attach;
    logic pp_on;
    logic orient_low;
    logic vconn1;
    logic vconn2;
    logic [NRW-1:0][7:0] rw;
  } state_s;
endpackage

//--- rtl/sync2.sv
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; multi-bit codes may skew by one cycle.
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clock, // System clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [W-1:0] din, // Asynchronous levels.
  output logic [W-1:0] dout // Synchronised levels.
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

//--- rtl/typec_source_port_state_outputs.sv
// Source-role attach logic of a Type-C port with its I2C register file and power-path outputs.
// Assumes analog comparators give each CC termination, VDD and VBUS conditions as async levels.
// Function
// - Power-path enable drives low only when attached, VDD not over lockout, VBUS valid.
// - Power-path enable releases as soon as any enabling condition fails.
// - Start-up power selection resets to 0, normal operation.
// - Cable supply discharge on CC pins resets disabled.
// - Cable supply capability resets enabled.
// - Power role field resets to source with accessory support, all zeros.
// - Cable supply undervoltage watch resets on, level select resets to high threshold.
// - Bus voltage target resets to the 5 V DAC code.
// - High and low window shifts each reset to code 1010b.
// - Discharge-to-zero time resets to code 1010b.
// - Discharge transition time resets to code 1010b.
// - Bus discharge path resets enabled.
// - Supply overvoltage detection disable resets to 0.
// - Zero-volt level select resets to 00b.
// - Supply undervoltage detection disable resets to 1.
// - Ra with open stays unattached, outputs released, no cable supply, status 00h.
// - Rd with Ra attaches, supplies Ra line, orientation low for Rd on CC2, 2Fh.
// - CC inputs mean the termination the partner presents.
// - Connection status shows only the settled codes; no transitional codes arise.
`timescale 1ns/1ps
`include "typec_src_defines.svh"
module typec_source_port_state_outputs
  import typec_src_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR
) (
  input wire logic clock, // System clock, 25 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic scl_in, // I2C clock pin level.
  input wire logic sda_in, // I2C data pin level.
  output logic sda_out, // I2C data output value, always low.
  output logic sda_oe, // I2C data pulls low while high.
  input wire logic [1:0] cc1_term, // Partner termination seen on CC1.
  input wire logic [1:0] cc2_term, // Partner termination seen on CC2.
  input wire logic vdd_present, // VDD pin is supplied.
  input wire logic vdd_over_lockout, // VDD above the overvoltage lockout level.
  input wire logic vbus_valid, // VBUS within its valid range.
  output logic source_power_path_enable_out, // Power-path pin value, always low.
  output logic source_power_path_enable_oe, // Power-path pin pulls low while high.
  output logic orientation_out, // Orientation pin value, always low.
  output logic orientation_oe, // Orientation pin pulls low while high.
  output logic vconn_cc1_on, // Cable supply switched to CC1.
  output logic vconn_cc2_on, // Cable supply switched to CC2.
  output config_s cfg // Configuration fields to the analog blocks.
);
  localparam logic [NRW-1:0][7:0] RW_OFS = {
    `OFS_SUPPLY, `OFS_DIS_CTRL, `OFS_DIS_TIME, `OFS_ACC, `OFS_SHIFT, `OFS_TARGET,
    `OFS_VCONN_MON, `OFS_ROLE, `OFS_ILIM, `OFS_CC_CTRL, `OFS_CONN
  };
  localparam logic [NRW-1:0][7:0] RW_RST = {
    `RST_SUPPLY, `RST_DIS_CTRL, `RST_DIS_TIME, `RST_ACC, `RST_SHIFT, `RST_TARGET,
    `RST_VCONN_MON, `RST_ROLE, `RST_ILIM, `RST_CC_CTRL, `RST_STARTUP
  };
  localparam logic [NRW-1:0][7:0] RW_MASK = {
    `MASK_SUPPLY, `MASK_DIS_CTRL, `MASK_DIS_TIME, `MASK_ACC, `MASK_SHIFT, `MASK_TARGET,
    `MASK_VCONN_MON, `MASK_ROLE, `MASK_ILIM, `MASK_CC_CTRL, `MASK_STARTUP
  };
  localparam logic [3:0] BYTE_BITS = 4'h8;

  state_s s;
  state_s next_s;
  logic [8:0] sync_out;
  logic scl_s;
  logic sda_s;
  term_e cc1;
  term_e cc2;
  logic vdd_present_s;
  logic vdd_ov_s;
  logic vbus_valid_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Every pin, the CC terminations included, passes two flops before any logic reads it. The flops
  // clear low while the bus idles high, so a false falling and then rising clock edge follow reset; the idle state ignores
  // clock edges, and no start condition can form from it.
  sync2 #(
    .W(9)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .din({scl_in, sda_in, cc1_term, cc2_term, vdd_present, vdd_over_lockout, vbus_valid}),
    .dout(sync_out)
  );

  assign scl_s = sync_out[8];
  assign sda_s = sync_out[7];
  assign cc1 = term_e'(sync_out[6:5]);
  assign cc2 = term_e'(sync_out[4:3]);
  assign vdd_present_s = sync_out[2];
  assign vdd_ov_s = sync_out[1];
  assign vbus_valid_s = sync_out[0];

  assign scl_rise = scl_s & ~s.scl_q;
  assign scl_fall = ~scl_s & s.scl_q;
  assign bus_start = scl_s & s.scl_q & s.sda_q & ~sda_s;
  assign bus_stop = scl_s & s.scl_q & ~s.sda_q & sda_s;

  // Decode of the partner terminations into the attach state. There is no debounce here: the
  // comparators are expected to deliver settled levels, so a glitch shows as a short state blip.
  function automatic attach_e decode_attach(input term_e c1, input term_e c2, input logic src_role);
    attach_e a;
    a = ST_UNATT;
    // A role code other than source with accessory support leaves the port unattached.
    if (src_role) begin
      if (c1 == TERM_RD && c2 == TERM_RD) begin
        a = ST_DBG;
      end else if (c1 == TERM_RA && c2 == TERM_RA) begin
        a = ST_AUDIO;
      end else if (c1 == TERM_RD && (c2 == TERM_OPEN || c2 == TERM_RA)) begin
        a = ST_ATT;
      end else if (c2 == TERM_RD && (c1 == TERM_OPEN || c1 == TERM_RA)) begin
        a = ST_ATT;
      end else begin
        a = ST_UNATT;
      end
    end
    return a;
  endfunction

  // Only the settled codes are produced; the transitional codes that software may see on a
  // full controller do not arise because the state changes in one step.
  function automatic logic [7:0] conn_code(input attach_e a, input logic cable);
    logic [7:0] c;
    c = `CONN_NONE;
    unique case (a)
      ST_UNATT: c = `CONN_NONE;
      ST_ATT: c = cable ? `CONN_SINK_CABLE : `CONN_SINK;
      ST_DBG: c = `CONN_DEBUG;
      ST_AUDIO: c = `CONN_AUDIO;
    endcase
    return c;
  endfunction

  function automatic logic [7:0] op_code(input attach_e a);
    logic [7:0] c;
    c = `OP_UNATTACHED;
    unique case (a)
      ST_UNATT: c = `OP_UNATTACHED;
      ST_ATT: c = `OP_ATTACHED;
      ST_DBG: c = `OP_DEBUG;
      ST_AUDIO: c = `OP_AUDIO;
    endcase
    return c;
  endfunction

  // The start-up bit shares the connection offset but is write-only; reads there return status.
  function automatic logic [7:0] read_byte(input state_s st);
    logic [7:0] d;
    d = 8'h00;
    if (st.ptr == `OFS_CONN) begin
      d = conn_code(st.attach, st.vconn1 | st.vconn2);
    end else if (st.ptr == `OFS_OP) begin
      d = op_code(st.attach);
    end else begin
      for (int i = 1; i < NRW; i++) begin
        if (RW_OFS[i] == st.ptr) begin
          d = st.rw[i] & RW_MASK[i];
        end
      end
    end
    return d;
  endfunction

  always_comb begin
    attach_e na;
    logic src_role;
    logic supply_ok;
    logic bus_ok;
    logic attached;
    logic [7:0] rb;
    na = ST_UNATT;
    src_role = 1'b0;
    supply_ok = 1'b0;
    bus_ok = 1'b0;
    attached = 1'b0;
    // One lookup of the addressed byte feeds both the shift register and the first data bit.
    rb = read_byte(s);
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;

    if (bus_start) begin
      next_s.bus = I_ADDR;
      next_s.cnt = 4'h0;
      next_s.sda_low = 1'b0;
    end else if (bus_stop) begin
      next_s.bus = I_IDLE;
      next_s.sda_low = 1'b0;
    end else begin
      unique case (s.bus)
        I_IDLE: begin
          next_s.sda_low = 1'b0;
        end
        I_ADDR, I_PTR, I_WDATA: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda_s};
            next_s.cnt = s.cnt + 4'h1;
          end else if (scl_fall && s.cnt == BYTE_BITS) begin
            next_s.cnt = 4'h0;
            next_s.sda_low = 1'b1;
            if (s.bus == I_ADDR) begin
              if (s.shreg[7:1] == DEV_ADDR) begin
                next_s.bus = I_ACK_ADDR;
              end else begin
                next_s.bus = I_IDLE;
                next_s.sda_low = 1'b0;
              end
            end else if (s.bus == I_PTR) begin
              next_s.ptr = s.shreg;
              next_s.bus = I_ACK_PTR;
            end else begin
              // Writes to read-only or unmapped offsets are acknowledged and dropped.
              for (int i = 0; i < NRW; i++) begin
                if (RW_OFS[i] == s.ptr) begin
                  next_s.rw[i] = s.shreg & RW_MASK[i];
                end
              end
              next_s.ptr = s.ptr + 8'h01;
              next_s.bus = I_ACK_W;
            end
          end
        end
        I_ACK_ADDR: begin
          if (scl_fall) begin
            if (s.shreg[0]) begin
              next_s.shreg = rb;
              next_s.sda_low = ~rb[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.bus = I_RDATA;
            end else begin
              next_s.sda_low = 1'b0;
              next_s.bus = I_PTR;
            end
          end
        end
        I_ACK_PTR, I_ACK_W: begin
          if (scl_fall) begin
            next_s.sda_low = 1'b0;
            next_s.bus = I_WDATA;
          end
        end
        I_RDATA: begin
          if (scl_rise) begin
            next_s.cnt = s.cnt + 4'h1;
          end else if (scl_fall) begin
            if (s.cnt == BYTE_BITS) begin
              next_s.cnt = 4'h0;
              next_s.sda_low = 1'b0;
              next_s.bus = I_ACK_R;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.sda_low = ~s.shreg[6];
            end
          end
        end
        I_ACK_R: begin
          // The master's acknowledge bit waits in the counter until the falling edge acts on it.
          if (scl_rise) begin
            next_s.cnt = {3'h0, sda_s};
          end else if (scl_fall) begin
            if (s.cnt[0]) begin
              next_s.bus = I_IDLE;
            end else begin
              next_s.shreg = rb;
              next_s.sda_low = ~rb[7];
              next_s.ptr = s.ptr + 8'h01;
              next_s.bus = I_RDATA;
            end
            next_s.cnt = 4'h0;
          end
        end
      endcase
    end

    src_role = (s.rw[3][3:0] == `ROLE_SOURCE_ACC);
    na = decode_attach(cc1, cc2, src_role);
    next_s.attach = na;
    attached = (na == ST_ATT) || (na == ST_DBG);
    // The bypass bits let the pin follow the attach state alone when a comparator is not fitted.
    supply_ok = ~vdd_present_s | s.rw[10][0] | ~vdd_ov_s;
    bus_ok = s.rw[10][1] | vbus_valid_s;
    next_s.pp_on = attached & supply_ok & bus_ok;
    // An unoriented debug accessory shows Rd on both lines, so it never drives the orientation pin.
    next_s.orient_low = (na == ST_ATT) && (cc2 == TERM_RD);
    next_s.vconn1 = (na == ST_ATT) && s.rw[1][0] && (cc1 == TERM_RA);
    next_s.vconn2 = (na == ST_ATT) && s.rw[1][0] && (cc2 == TERM_RA);
  end

  // The asynchronous reset loads only constants, the register defaults included.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s.bus <= I_IDLE;
      s.cnt <= 4'h0;
      s.shreg <= 8'h00;
      s.ptr <= 8'h00;
      s.sda_low <= 1'b0;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.attach <= ST_UNATT;
      s.pp_on <= 1'b0;
      s.orient_low <= 1'b0;
      s.vconn1 <= 1'b0;
      s.vconn2 <= 1'b0;
      s.rw <= RW_RST;
    end else begin
      s <= next_s;
    end
  end

  // Open-drain pins: the values stay low and only the enables move, so no open-drain pin is ever driven high.
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_low;
  assign source_power_path_enable_out = 1'b0;
  assign source_power_path_enable_oe = s.pp_on;
  assign orientation_out = 1'b0;
  assign orientation_oe = s.orient_low;
  assign vconn_cc1_on = s.vconn1;
  assign vconn_cc2_on = s.vconn2;

  assign cfg.startup_standby = s.rw[0][0];
  assign cfg.advertised_current_field = s.rw[1][7:6];
  assign cfg.cable_supply_discharge_on = s.rw[1][4];
  assign cfg.cable_supply_allow = s.rw[1][0];
  assign cfg.cable_supply_current_limit = s.rw[2][3:0];
  assign cfg.power_role = s.rw[3][3:0];
  assign cfg.cable_supply_uv_watch_on = s.rw[4][0];
  assign cfg.cable_supply_uv_level = s.rw[4][1];
  assign cfg.bus_voltage_target = s.rw[5];
  assign cfg.bus_window_high_shift = s.rw[6][7:4];
  assign cfg.bus_window_low_shift = s.rw[6][3:0];
  assign cfg.powered_accessory_detect_on = s.rw[7][0];
  assign cfg.discharge_to_zero_time = s.rw[8][7:4];
  assign cfg.discharge_transition_time = s.rw[8][3:0];
  assign cfg.bus_discharge_on = s.rw[9][0];
  assign cfg.supply_ov_detect_off = s.rw[10][0];
  assign cfg.bus_range_detect_off = s.rw[10][1];
  assign cfg.bus_zero_volt_level = s.rw[10][3:2];
  assign cfg.supply_uv_detect_off = s.rw[10][4];
endmodule

//--- test/typec_src_sva.sv
// Checker for the source port block: power path, orientation, cable supply and reset defaults.
// Assumes outputs follow pin levels three clocks later: two sync flops plus one state flop.
`timescale 1ns/1ps
module typec_src_sva
  import typec_src_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Async reset, active high.
  input wire logic [1:0] cc1_term, // CC1 termination.
  input wire logic [1:0] cc2_term, // CC2 termination.
  input wire logic vdd_present, // VDD supplied.
  input wire logic vdd_over_lockout, // VDD over lockout.
  input wire logic vbus_valid, // VBUS in range.
  input wire logic source_power_path_enable_oe, // Power path driven.
  input wire logic orientation_oe, // Orientation driven.
  input wire logic vconn_cc1_on, // Supply on CC1.
  input wire logic vconn_cc2_on, // Supply on CC2.
  input wire config_s cfg // Register fields.
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  pp_vbus_a: assert property (
    source_power_path_enable_oe |-> cfg.bus_range_detect_off || $past(vbus_valid, 3))
    else $error("power path on with bus out of range");
  pp_vdd_a: assert property (
    source_power_path_enable_oe |-> cfg.supply_ov_detect_off || !($past(vdd_present, 3) && $past(vdd_over_lockout, 3)))
    else $error("power path on with supply over lockout");
  pp_release_a: assert property (
    $fell(vbus_valid) && !cfg.bus_range_detect_off |-> ##3 !source_power_path_enable_oe)
    else $error("power path not released after bus left range");
  // Sink on CC1 only, bus valid, no supply on the VDD pin.
  sink_attach_a: assert property (
    $past({cc1_term, cc2_term, vbus_valid, vdd_present}, 3) == {TERM_RD, TERM_OPEN, 2'b10} && cfg.power_role == 4'h0
    |-> source_power_path_enable_oe && !orientation_oe && !vconn_cc1_on && !vconn_cc2_on)
    else $error("sink attach outputs wrong");
  orient_cc2_a: assert property (
    orientation_oe |-> $past(cc2_term, 3) == TERM_RD)
    else $error("orientation driven without sink on CC2");
  cable_cc2_a: assert property (
    vconn_cc2_on |-> $past({cc1_term, cc2_term}, 3) == {TERM_RD, TERM_RA} && cfg.cable_supply_allow && !vconn_cc1_on)
    else $error("cable supply on CC2 without cable there");
  cable_cc1_a: assert property (
    vconn_cc1_on |-> $past({cc1_term, cc2_term}, 3) == {TERM_RA, TERM_RD} && cfg.cable_supply_allow && !vconn_cc2_on)
    else $error("cable supply on CC1 without cable there");
  unattached_pins_a: assert property (
    $past({cc1_term, cc2_term}, 3) inside {4'h0, 4'h1, 4'h4, 4'hf}
    |-> !source_power_path_enable_oe && !orientation_oe && !vconn_cc1_on && !vconn_cc2_on)
    else $error("outputs active while unattached");
  cfg_default_a: assert property (
    $fell(rst) |-> !cfg.startup_standby && !cfg.supply_ov_detect_off && cfg.supply_uv_detect_off)
    else $error("configuration defaults wrong after reset");
endmodule

bind typec_source_port_state_outputs typec_src_sva i_typec_src_sva (
  .clock, .rst, .cc1_term, .cc2_term, .vdd_present, .vdd_over_lockout, .vbus_valid,
  .source_power_path_enable_oe, .orientation_oe, .vconn_cc1_on, .vconn_cc2_on, .cfg
);

//--- test/typec_partner.sv
// Far-side model: the terminations a sink, cable or accessory presents on CC1 and CC2.
// Assumes the bench picks the attached party and the plug flip; levels hold until told.
`timescale 1ns/1ps
module typec_partner
  import typec_src_pkg::*;
(
  input wire logic [2:0] kind, // 0 none, 1 sink, 2 cable, 3 cable and sink, 4 Rp pair, 5 Rd pair, 6 Ra pair.
  input wire logic flip, // Plug turned over.
  output logic [1:0] cc1_term, // Termination on CC1.
  output logic [1:0] cc2_term // Termination on CC2.
);
  term_e a;
  term_e b;
  // These are what this party presents, never what the port applies itself.
  always_comb begin
    a = TERM_OPEN;
    b = TERM_OPEN;
    case (kind)
      3'h1: a = TERM_RD;
      3'h2: a = TERM_RA;
      3'h3: begin
        a = TERM_RD;
        b = TERM_RA;
      end
      3'h4: begin
        a = TERM_RP;
        b = TERM_RP;
      end
      3'h5: begin
        a = TERM_RD;
        b = TERM_RD;
      end
      3'h6: begin
        a = TERM_RA;
        b = TERM_RA;
      end
      default: ;
    endcase
    cc1_term = flip ? b : a;
    cc2_term = flip ? a : b;
  end
endmodule

//--- test/testbench.sv
// Self-checking bench: I2C register access, reset defaults and the attach table with random supplies.
// Assumes the block answers at the default bus address and outputs settle three clocks after a pin change.
`timescale 1ns/1ps
`include "typec_src_defines.svh"
module testbench
  import typec_src_pkg::*;
;
  localparam logic [15:0] DEFS [10] = '{16'h1801, 16'h1e00, 16'h1f00, 16'h2001, 16'h2132, 16'h22aa,
                                        16'h25aa, 16'h2601, 16'h2e10, 16'h3000};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic scl_in = 1'b1;
  logic sda_m = 1'b1;
  logic sda_in;
  logic sda_oe;
  logic [2:0] kind = 3'h0;
  logic flip = 1'b0;
  logic [1:0] cc1_term;
  logic [1:0] cc2_term;
  logic vdd_present = 1'b0;
  logic vdd_over_lockout = 1'b0;
  logic vbus_valid = 1'b0;
  logic source_power_path_enable_oe;
  logic orientation_oe;
  logic vconn_cc1_on;
  logic vconn_cc2_on;
  logic [3:0] pins;
  logic [2:0] od_val;
  config_s cfg;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  // Open-drain data line: low when either side pulls it.
  assign sda_in = sda_m & ~sda_oe;
  assign pins = {source_power_path_enable_oe, orientation_oe, vconn_cc1_on, vconn_cc2_on};

  typec_source_port_state_outputs i_typec_source_port_state_outputs (
    .clock, .rst, .scl_in, .sda_in, .sda_out(od_val[2]), .sda_oe, .cc1_term, .cc2_term, .vdd_present,
    .vdd_over_lockout, .vbus_valid, .source_power_path_enable_out(od_val[1]), .source_power_path_enable_oe,
    .orientation_out(od_val[0]), .orientation_oe,
    .vconn_cc1_on, .vconn_cc2_on, .cfg
  );
  typec_partner i_typec_partner (.kind, .flip, .cc1_term, .cc2_term);

  always #20 clock = ~clock;

  task automatic tally_and_finish();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // The whole run needs about 29000 cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Each bus phase lasts four clocks, above the three the slave needs.
  task automatic ph(input logic c, input logic d);
    @(posedge clock);
    scl_in <= c;
    sda_m <= d;
    repeat (3) @(posedge clock);
  endtask

  task automatic start();
    ph(1'b1, 1'b1);
    ph(1'b1, 1'b0);
    ph(1'b0, 1'b0);
  endtask

  task automatic stop();
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic want_ack, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, tx[i]);
      ph(1'b1, tx[i]);
      rx[i] = sda_in;
      ph(1'b0, tx[i]);
    end
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    if (want_ack) chk("ack", 8'h00, {7'h0, sda_in});
    ph(1'b0, 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, x);
    xfer(a, 1'b1, x);
    xfer(d, 1'b1, x);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    start();
    xfer({`I2C_DEV_ADDR, 1'b0}, 1'b1, x);
    xfer(a, 1'b1, x);
    start();
    xfer({`I2C_DEV_ADDR, 1'b1}, 1'b1, x);
    xfer(8'hff, 1'b0, d);
    stop();
  endtask

  // Connection code, attach state code and {power path, orientation, supply CC1, supply CC2}.
  function automatic logic [19:0] expect_of(input logic [2:0] k, input logic f);
    case (k)
      3'h1: return {8'h2d, 8'h01, 1'b1, f, 2'b00};
      3'h3: return {8'h2f, 8'h01, 1'b1, f, f, !f};
      3'h5: return {8'h6d, 8'h02, 4'h8};
      3'h6: return {8'h81, 8'h03, 4'h0};
      default: return 20'h0;
    endcase
  endfunction

  initial begin
    logic [7:0] d;
    logic [19:0] e;
    logic [2:0] k;
    logic f;
    logic v;
    logic p;
    logic o;
    void'($urandom(32'hf9c1));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    foreach (DEFS[j]) begin
      e[15:0] = DEFS[j];
      rd(e[15:8], d);
      chk($sformatf("reg %h", e[15:8]), e[7:0], d);
    end
    $display("test defaults done");
    // A write to the read-only state register must leave the reported codes alone.
    wr(8'h11, 8'hff);
    for (int i = 0; i < 24; i++) begin
      k = (i < 14) ? 3'(i / 2) : 3'($urandom_range(6, 0));
      f = (i < 14) ? i[0] : 1'($urandom);
      v = (i < 14) || 1'($urandom);
      p = (i >= 14) && 1'($urandom);
      o = 1'($urandom);
      @(posedge clock);
      kind <= k;
      flip <= f;
      vbus_valid <= v;
      vdd_present <= p;
      vdd_over_lockout <= o;
      repeat (6) @(posedge clock);
      @(negedge clock);
      e = expect_of(k, f);
      e[3] = e[3] & v & ~(p & o);
      chk("pins", {4'h0, e[3:0]}, {4'h0, pins});
      chk("pin levels", 8'h00, {5'h0, od_val});
      rd(8'h0e, d);
      chk("connection", e[19:12], d);
      rd(8'h11, d);
      chk("attach state", e[11:4], d);
    end
    $display("test attach done");
    d = 8'($urandom);
    wr(8'h21, d);
    rd(8'h21, e[7:0]);
    chk("target write", d, e[7:0]);
    kind <= 3'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h21, d);
    chk("target after reset", 8'h32, d);
    chk("target field", 8'h32, cfg.bus_voltage_target);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
